/* File: shared/cbl_regs.vh */
// Constants for the cassette backup loader: register map, fields, codes.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef CBL_REGS_VH
`define CBL_REGS_VH
// Register byte offsets.
`define CBL_OFF_CTRL 8'h00
`define CBL_OFF_BLK 8'h04
`define CBL_OFF_STAT 8'h08
`define CBL_OFF_IRQS 8'h0C
`define CBL_OFF_IRQM 8'h10
`define CBL_OFF_DATE 8'h14
`define CBL_OFF_TIME 8'h18
// Control register fields.
`define CBL_CTRL_START 0
`define CBL_CTRL_DIR 1
`define CBL_CTRL_OPT_LO 2
`define CBL_CTRL_OPT_HI 4
// Block range fields.
`define CBL_BLK_START_HI 4
`define CBL_BLK_CNT_LO 8
`define CBL_BLK_CNT_HI 13
// Interrupt bits.
`define CBL_IRQ_DONE 0
`define CBL_IRQ_ERR 1
`define CBL_IRQ_IOCHK 2
// Error codes.
`define CBL_ERR_NONE 8'h00
`define CBL_ERR_PROC 8'h2A
`define CBL_ERR_MODE 8'h3F
`define CBL_ERR_PROT 8'h41
`define CBL_ERR_NOSTORE 8'hF0
`define CBL_ERR_IOCHK 8'hF1
`define CBL_ERR_BUSY 8'hF2
// Item identifiers in copy order.
`define CBL_ITEM_EDIT_MODE 3'h0
`define CBL_ITEM_UPL 3'h4
`define CBL_ITEM_FLASH 3'h6
// Words per flash block, as a shift: 2K words.
`define CBL_BLK_SHIFT 11
// Clock rate and one second.
`define CBL_CLK_HZ 40000000
`define CBL_TICK_S 1
// Reset values of the clock fields.
`define CBL_RST_MONTH 4'h1
`define CBL_RST_DAY 5'h01
`endif

/* File: rtl/cbl_top.v */
// Cassette backup loader: copy sequencer, clock/calendar and APB registers.
// Assumes synchronous inputs on clock_in and a host datapath that moves items.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cbl_regs.vh"
module cbl_top #(
   parameter TICK_CYCLES = `CBL_CLK_HZ * `CBL_TICK_S
) (
   // Clock and reset.
   input wire clock_in,
   input wire reset_n_in,
   // APB slave.
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [7:0] paddr_in,
   input wire [31:0] pwdata_in,
   output wire pready_out,
   output reg [31:0] prdata_out,
   output reg pslverr_out,
   // Cassette and controller state.
   input wire func_switch_in,
   input wire cassette_present_in,
   input wire cassette_comment_in,
   input wire cassette_flash_in,
   input wire run_mode_in,
   input wire unconverted_in,
   input wire edit_request_in,
   // Item copy handshake to the host datapath.
   output reg item_req_out,
   output reg [2:0] item_id_out,
   output reg item_restore_out,
   output reg item_erase_out,
   output reg [15:0] item_addr_out,
   input wire item_done_in,
   input wire item_match_in,
   // Status.
   output wire backup_enable_out,
   output wire edit_allow_out,
   output reg edit_refused_out,
   output wire irq_out
);

   localparam ST_IDLE = 2'd0;
   localparam ST_ISSUE = 2'd1;
   localparam ST_WAIT = 2'd2;

   // Days in a month; February gains a day in years divisible by four.
   function [4:0] cbl_days;
      input [3:0] month;
      input [6:0] year;
      begin
         case (month)
            4'd2: cbl_days = (year[1:0] == 2'b00) ? 5'd29 : 5'd28;
            4'd4, 4'd6, 4'd9, 4'd11: cbl_days = 5'd30;
            default: cbl_days = 5'd31;
         endcase
      end
   endfunction

   reg rst_meta_reg;
   reg rst_sync_reg;
   wire rst_n = rst_sync_reg;

   // Reset release through two flip-flops.
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   reg [4:0] ctrl_reg;
   reg [13:0] blk_reg;
   reg [2:0] irqs_reg;
   reg [2:0] irqm_reg;
   reg [7:0] err_reg;
   reg [1:0] state_reg;
   reg [2:0] item_reg;
   reg auto_reg;
   reg [2:0] opt_reg;
   reg [4:0] blkno_reg;
   reg [5:0] left_reg;
   reg restored_reg;
   reg pwrup_reg;
   reg run_prev_reg;
   reg pres_prev_reg;
   reg [4:0] sv_start_reg;
   reg [5:0] sv_cnt_reg;
   reg [25:0] tick_reg;
   reg [6:0] year_reg;
   reg [3:0] month_reg;
   reg [4:0] day_reg;
   reg [2:0] wday_reg;
   reg [4:0] hour_reg;
   reg [5:0] min_reg;
   reg [5:0] sec_reg;

   wire wr_en = psel_in & penable_in & pwrite_in;
   wire rd_setup = psel_in & ~penable_in & ~pwrite_in;
   wire store_ok = func_switch_in & cassette_present_in;
   wire busy = (state_reg != ST_IDLE);
   wire tool_req = wr_en & (paddr_in == `CBL_OFF_CTRL) & pwdata_in[`CBL_CTRL_START];
   wire req_restore = pwdata_in[`CBL_CTRL_DIR];
   wire pres_change = ~pwrup_reg & (cassette_present_in != pres_prev_reg);
   wire auto_trig = store_ok & run_mode_in & (pwrup_reg | ~run_prev_reg);
   wire tick = (tick_reg == TICK_CYCLES - 1);

   assign pready_out = 1'b1;
   assign backup_enable_out = store_ok;
   assign edit_allow_out = ~cassette_present_in;
   assign irq_out = |(irqs_reg & irqm_reg);

   // Read data and error answer are latched in the setup cycle.
   always @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         prdata_out <= 32'h0000_0000;
         pslverr_out <= 1'b0;
      end else if (psel_in & ~penable_in) begin
         pslverr_out <= (paddr_in[1:0] != 2'b00) | (paddr_in > `CBL_OFF_TIME);
         prdata_out <= 32'h0000_0000;
         if (rd_setup) begin
            case (paddr_in)
               `CBL_OFF_CTRL: prdata_out <= {27'h0, ctrl_reg[4:1], 1'b0};
               `CBL_OFF_BLK: prdata_out <= {18'h0, blk_reg};
               `CBL_OFF_STAT: prdata_out <= {16'h0, err_reg, cassette_flash_in,
                  cassette_comment_in, restored_reg, run_mode_in, cassette_present_in,
                  func_switch_in, store_ok, busy};
               `CBL_OFF_IRQS: prdata_out <= {29'h0, irqs_reg};
               `CBL_OFF_IRQM: prdata_out <= {29'h0, irqm_reg};
               `CBL_OFF_DATE: prdata_out <= {1'b0, year_reg, 4'h0, month_reg, 3'h0,
                  day_reg, 5'h0, wday_reg};
               `CBL_OFF_TIME: prdata_out <= {11'h0, hour_reg, 2'h0, min_reg, 2'h0, sec_reg};
               default: prdata_out <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Software-written control, block range and mask.
   always @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= 5'h00;
         blk_reg <= 14'h0000;
         irqm_reg <= 3'h0;
      end else if (wr_en) begin
         case (paddr_in)
            `CBL_OFF_CTRL: ctrl_reg <= {pwdata_in[`CBL_CTRL_OPT_HI:`CBL_CTRL_DIR], 1'b0};
            `CBL_OFF_BLK: blk_reg <= {pwdata_in[`CBL_BLK_CNT_HI:`CBL_BLK_CNT_LO], 3'h0,
               pwdata_in[`CBL_BLK_START_HI:0]};
            `CBL_OFF_IRQM: irqm_reg <= pwdata_in[2:0];
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // Clock/calendar; it keeps time whatever the function switch says.
   always @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         tick_reg <= 26'h000_0000;
         year_reg <= 7'h00;
         month_reg <= `CBL_RST_MONTH;
         day_reg <= `CBL_RST_DAY;
         wday_reg <= 3'h0;
         hour_reg <= 5'h00;
         min_reg <= 6'h00;
         sec_reg <= 6'h00;
      end else if (wr_en & (paddr_in == `CBL_OFF_DATE)) begin
         year_reg <= pwdata_in[30:24];
         month_reg <= pwdata_in[19:16];
         day_reg <= pwdata_in[12:8];
         wday_reg <= pwdata_in[2:0];
      end else if (wr_en & (paddr_in == `CBL_OFF_TIME)) begin
         hour_reg <= pwdata_in[20:16];
         min_reg <= pwdata_in[13:8];
         sec_reg <= pwdata_in[5:0];
         tick_reg <= 26'h000_0000;
      end else if (!tick) begin
         tick_reg <= tick_reg + 26'h000_0001;
      end else begin
         tick_reg <= 26'h000_0000;
         sec_reg <= (sec_reg == 6'd59) ? 6'd0 : sec_reg + 6'd1;
         if (sec_reg == 6'd59) begin
            min_reg <= (min_reg == 6'd59) ? 6'd0 : min_reg + 6'd1;
            if (min_reg == 6'd59) begin
               hour_reg <= (hour_reg == 5'd23) ? 5'd0 : hour_reg + 5'd1;
               if (hour_reg == 5'd23) begin
                  wday_reg <= (wday_reg == 3'd6) ? 3'd0 : wday_reg + 3'd1;
                  if (day_reg >= cbl_days(month_reg, year_reg)) begin
                     day_reg <= 5'd1;
                     month_reg <= (month_reg == 4'd12) ? 4'd1 : month_reg + 4'd1;
                     if (month_reg == 4'd12) begin
                        year_reg <= (year_reg == 7'd99) ? 7'd0 : year_reg + 7'd1;
                     end
                  end else begin
                     day_reg <= day_reg + 5'd1;
                  end
               end
            end
         end
      end
   end

   // Request screening: which request starts and which error it earns.
   reg ev_done;
   reg ev_err;
   reg [7:0] err_next;
   reg start_tool;
   always @* begin
      ev_err = 1'b0;
      err_next = err_reg;
      start_tool = 1'b0;
      if (pres_change) begin
         ev_err = 1'b1;
         err_next = `CBL_ERR_IOCHK;
      end else if (edit_request_in & cassette_present_in) begin
         ev_err = 1'b1;
         err_next = `CBL_ERR_PROT;
      end else if (tool_req) begin
         ev_err = 1'b1;
         if (!store_ok) begin
            err_next = `CBL_ERR_NOSTORE;
         end else if (busy) begin
            err_next = `CBL_ERR_BUSY;
         end else if (unconverted_in) begin
            err_next = `CBL_ERR_PROC;
         end else if (req_restore & run_mode_in) begin
            err_next = `CBL_ERR_MODE;
         end else begin
            ev_err = 1'b0;
            err_next = `CBL_ERR_NONE;
            start_tool = 1'b1;
         end
      end
   end

   // Current item: selected, and for restore whether it may be skipped.
   wire opt_item = (item_reg >= `CBL_ITEM_UPL);
   wire [1:0] opt_idx = item_reg[1:0];
   wire item_sel = ~opt_item | opt_reg[opt_idx];
   wire no_blocks = (item_reg == `CBL_ITEM_FLASH) & (left_reg == 6'd0);
   wire skip_match = auto_reg & restored_reg & item_match_in;
   wire do_copy = item_restore_out ? (item_sel & ~no_blocks & ~skip_match)
                                   : ~(item_sel & no_blocks);

   // Copy sequencer walking the item list.
   always @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         item_reg <= `CBL_ITEM_EDIT_MODE;
         auto_reg <= 1'b0;
         opt_reg <= 3'h0;
         blkno_reg <= 5'h00;
         left_reg <= 6'h00;
         restored_reg <= 1'b0;
         sv_start_reg <= 5'h00;
         sv_cnt_reg <= 6'h00;
         item_req_out <= 1'b0;
         item_id_out <= 3'h0;
         item_restore_out <= 1'b0;
         item_erase_out <= 1'b0;
         item_addr_out <= 16'h0000;
         ev_done <= 1'b0;
      end else begin
         ev_done <= 1'b0;
         if (pres_change | ~store_ok) begin
            // A changed cassette or a store switched off aborts any copy.
            // Only a changed cassette forgets the last restore.
            state_reg <= ST_IDLE;
            item_req_out <= 1'b0;
            restored_reg <= restored_reg & ~pres_change;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  item_reg <= `CBL_ITEM_EDIT_MODE;
                  if (auto_trig) begin
                     // Whole cassette content, overwriting the controller.
                     state_reg <= ST_ISSUE;
                     auto_reg <= 1'b1;
                     item_restore_out <= 1'b1;
                     opt_reg <= {cassette_flash_in, cassette_comment_in, 1'b1};
                     blkno_reg <= sv_start_reg;
                     left_reg <= sv_cnt_reg;
                  end else if (start_tool) begin
                     state_reg <= ST_ISSUE;
                     auto_reg <= 1'b0;
                     item_restore_out <= req_restore;
                     blkno_reg <= blk_reg[4:0];
                     left_reg <= blk_reg[13:8];
                     if (req_restore) begin
                        // Absent regions cannot be chosen.
                        opt_reg <= pwdata_in[`CBL_CTRL_OPT_HI:`CBL_CTRL_OPT_LO] &
                           {cassette_flash_in, cassette_comment_in, 1'b1};
                     end else begin
                        opt_reg <= pwdata_in[`CBL_CTRL_OPT_HI:`CBL_CTRL_OPT_LO];
                        sv_start_reg <= blk_reg[4:0];
                        sv_cnt_reg <= pwdata_in[`CBL_CTRL_OPT_HI] ? blk_reg[13:8] : 6'h00;
                     end
                  end
               end
               ST_ISSUE: begin
                  if (do_copy) begin
                     item_req_out <= 1'b1;
                     item_id_out <= item_reg;
                     item_erase_out <= ~item_restore_out & ~item_sel;
                     item_addr_out <= {blkno_reg, 11'h000} & {16{item_reg ==
                        `CBL_ITEM_FLASH}};
                     state_reg <= ST_WAIT;
                  end else if (item_reg == `CBL_ITEM_FLASH) begin
                     state_reg <= ST_IDLE;
                     ev_done <= 1'b1;
                     restored_reg <= restored_reg | item_restore_out;
                  end else begin
                     item_reg <= item_reg + 3'd1;
                  end
               end
               ST_WAIT: begin
                  if (item_done_in) begin
                     item_req_out <= 1'b0;
                     if ((item_reg == `CBL_ITEM_FLASH) & ~item_erase_out & (left_reg > 6'd1)) begin
                        blkno_reg <= blkno_reg + 5'd1;
                        left_reg <= left_reg - 6'd1;
                        state_reg <= ST_ISSUE;
                     end else if (item_reg == `CBL_ITEM_FLASH) begin
                        state_reg <= ST_IDLE;
                        ev_done <= 1'b1;
                        restored_reg <= restored_reg | item_restore_out;
                     end else begin
                        item_reg <= item_reg + 3'd1;
                        state_reg <= ST_ISSUE;
                     end
                  end
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // Mode tracking, error code, edit refusal and sticky interrupt status.
   always @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         pwrup_reg <= 1'b1;
         run_prev_reg <= 1'b0;
         pres_prev_reg <= 1'b0;
         err_reg <= `CBL_ERR_NONE;
         edit_refused_out <= 1'b0;
         irqs_reg <= 3'h0;
      end else begin
         pwrup_reg <= 1'b0;
         run_prev_reg <= run_mode_in;
         pres_prev_reg <= cassette_present_in;
         err_reg <= err_next;
         edit_refused_out <= edit_request_in & cassette_present_in;
         // A new event wins over a write-one clear in the same cycle.
         irqs_reg <= (irqs_reg & ~({3{wr_en & (paddr_in == `CBL_OFF_IRQS)}} & pwdata_in[2:0]))
            | {pres_change, ev_err, ev_done};
      end
   end

endmodule
`default_nettype wire

/* File: tb/cbl_top_chk.sv */
// Concurrent checks on the ports of the cassette backup loader top.
// Assumes one clock domain and the active-low reset at the top's pins.
`timescale 1ns/1ps
`default_nettype none
module cbl_top_chk (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic reset_n_in,
   // Cassette, controller and host inputs.
   input wire logic func_switch_in,
   input wire logic cassette_present_in,
   input wire logic cassette_comment_in,
   input wire logic cassette_flash_in,
   input wire logic edit_request_in,
   input wire logic item_done_in,
   // Copy handshake and status outputs.
   input wire logic item_req_out,
   input wire logic [2:0] item_id_out,
   input wire logic item_restore_out,
   input wire logic item_erase_out,
   input wire logic [15:0] item_addr_out,
   input wire logic backup_enable_out,
   input wire logic edit_allow_out,
   input wire logic edit_refused_out
);
   logic [1:0] up_cnt;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);
   // Counts edges after reset so the internal reset copy has been released.
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in)
         up_cnt <= 2'h0;
      else if (up_cnt != 2'h3)
         up_cnt <= up_cnt + 2'h1;
   end
   enable_match_a: assert property (backup_enable_out == (func_switch_in && cassette_present_in))
      else $error("backup enable does not follow switch and cassette");
   edit_allow_a: assert property (edit_allow_out == !cassette_present_in)
      else $error("edit allow does not follow cassette presence");
   edit_refuse_a: assert property (up_cnt == 2'h3 |=> edit_refused_out == $past(edit_request_in && cassette_present_in))
      else $error("edit refusal pulse wrong");
   item_stable_a: assert property (item_req_out && $past(item_req_out) |-> $stable(item_id_out)
      && $stable(item_addr_out) && $stable(item_erase_out) && $stable(item_restore_out))
      else $error("item fields changed during a request");
   done_drop_a: assert property (item_req_out && item_done_in |-> ##1 !item_req_out)
      else $error("request did not drop after done");
   start_store_a: assert property ($rose(item_req_out) |-> backup_enable_out)
      else $error("request issued without an enabled store");
   flash_addr_a: assert property (item_req_out |-> ((item_id_out == 3'h6) ?
      (item_addr_out[10:0] == 11'h000) : (item_addr_out == 16'h0000)))
      else $error("item address not on a block boundary");
   restore_erase_a: assert property (item_req_out && item_restore_out |-> !item_erase_out)
      else $error("erase requested during a restore");
   region_avail_a: assert property ($rose(item_req_out) && item_restore_out && item_id_out >= 3'h5
      |-> ((item_id_out == 3'h5) ? cassette_comment_in : cassette_flash_in))
      else $error("absent region restored");
endmodule
bind cbl_top cbl_top_chk chk (.clock_in(clock_in), .reset_n_in(reset_n_in),
   .func_switch_in(func_switch_in), .cassette_present_in(cassette_present_in),
   .cassette_comment_in(cassette_comment_in), .cassette_flash_in(cassette_flash_in),
   .edit_request_in(edit_request_in), .item_done_in(item_done_in), .item_req_out(item_req_out),
   .item_id_out(item_id_out), .item_restore_out(item_restore_out),
   .item_erase_out(item_erase_out), .item_addr_out(item_addr_out),
   .backup_enable_out(backup_enable_out), .edit_allow_out(edit_allow_out),
   .edit_refused_out(edit_refused_out));
`default_nettype wire

/* File: tb/cbl_host_model.sv */
// Host datapath model that moves one item or one 2K-word block per request.
// Assumes the loader's level request and a one-cycle done pulse in reply.
`timescale 1ns/1ps
`default_nettype none
module cbl_host_model (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic reset_n_in,
   // Request from the loader and bench controls.
   input wire logic item_req_out,
   input wire logic slow_in,
   input wire logic match_in,
   // Answers to the loader.
   output logic item_done_in,
   output logic item_match_in
);
   logic [3:0] wait_cnt;
   logic sent;
   // Both stores keep their content, so the match level is given by the bench.
   assign item_match_in = match_in;
   // Answers every request once, promptly or after ten cycles.
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wait_cnt <= 4'h0;
         sent <= 1'h0;
         item_done_in <= 1'h0;
      end else begin
         item_done_in <= 1'h0;
         if (!item_req_out) begin
            wait_cnt <= 4'h0;
            sent <= 1'h0;
         end else if (!sent && wait_cnt >= (slow_in ? 4'h9 : 4'h0)) begin
            item_done_in <= 1'h1;
            sent <= 1'h1;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/cassette_backup_loader_tb.sv */
// Self-checking bench for the cassette backup loader.
// Assumes the design top, its bound checker and the host datapath model.
`timescale 1ns/1ps
`default_nettype none
`include "cbl_regs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module cassette_backup_loader_tb;
   typedef struct {logic [31:0] ctrl; logic [31:0] blk; logic com; logic fl; int n;
      logic [6:0] ids; logic [6:0] ers; logic [15:0] fa;} cbl_row_t;
   localparam int TICK = 40;
   logic clock_in = 1'h0, reset_n_in = 1'h0, psel_in = 1'h0, penable_in = 1'h0;
   logic pwrite_in = 1'h0, func_switch_in = 1'h1, cassette_present_in = 1'h1;
   logic cassette_comment_in = 1'h1, cassette_flash_in = 1'h1, run_mode_in = 1'h0;
   logic unconverted_in = 1'h0, edit_request_in = 1'h0, slow = 1'h0, match = 1'h0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, rd;
   logic pready_out, pslverr_out, item_req_out, item_restore_out, item_erase_out, item_done_in;
   logic item_match_in, backup_enable_out, edit_allow_out, edit_refused_out, irq_out, se;
   logic [2:0] item_id_out;
   logic [15:0] item_addr_out, fa;
   logic [6:0] ids, ers;
   logic prev_req = 1'h0, rst_all;
   int n_req, compares = 0, num_errors = 0, i;
   cbl_row_t rows [5];
   cbl_top #(.TICK_CYCLES(TICK)) DUT (.clock_in(clock_in), .reset_n_in(reset_n_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .pready_out(pready_out), .prdata_out(prdata_out),
      .pslverr_out(pslverr_out), .func_switch_in(func_switch_in),
      .cassette_present_in(cassette_present_in), .cassette_comment_in(cassette_comment_in),
      .cassette_flash_in(cassette_flash_in), .run_mode_in(run_mode_in),
      .unconverted_in(unconverted_in), .edit_request_in(edit_request_in),
      .item_req_out(item_req_out), .item_id_out(item_id_out), .item_restore_out(item_restore_out),
      .item_erase_out(item_erase_out), .item_addr_out(item_addr_out), .item_done_in(item_done_in),
      .item_match_in(item_match_in), .backup_enable_out(backup_enable_out),
      .edit_allow_out(edit_allow_out), .edit_refused_out(edit_refused_out), .irq_out(irq_out));
   cbl_host_model host (.clock_in(clock_in), .reset_n_in(reset_n_in), .item_req_out(item_req_out),
      .slow_in(slow), .match_in(match), .item_done_in(item_done_in), .item_match_in(item_match_in));
   // Makes the 40 MHz clock.
   always #12.5 clock_in = ~clock_in;
   // Records every new item request for the scenario checks.
   always @(posedge clock_in) begin
      prev_req <= item_req_out;
      if (item_req_out && !prev_req) begin
         n_req = n_req + 1;
         ids[item_id_out] = 1'h1;
         ers[item_id_out] = ers[item_id_out] | item_erase_out;
         rst_all = rst_all & item_restore_out;
         if (item_id_out == 3'h6 && fa == 16'h0000)
            fa = item_addr_out;
      end
   end
   task automatic summarize;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // One APB transfer; read data and error flag land in rd and se.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock_in);
      psel_in <= 1'h1;
      penable_in <= 1'h0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      n = 0;
      @(posedge clock_in);
      penable_in <= 1'h1;
      do begin
         @(posedge clock_in);
         n++;
      end while (pready_out !== 1'h1 && n < 20);
      if (n >= 20) begin
         num_errors++;
         summarize();
      end
      rd = prdata_out;
      se = pslverr_out;
      psel_in <= 1'h0;
      penable_in <= 1'h0;
   endtask
   task automatic clr;
      n_req = 0;
      ids = 7'h00;
      ers = 7'h00;
      fa = 16'h0000;
      rst_all = 1'h1;
   endtask
   task automatic go(input logic [31:0] c, input logic [31:0] b);
      clr();
      apb(1'h1, `CBL_OFF_BLK, b);
      apb(1'h1, `CBL_OFF_CTRL, c);
   endtask
   // Polls the busy bit until the copy has finished.
   task automatic wait_idle;
      int k;
      repeat (3) @(posedge clock_in);
      for (k = 0; k < 300; k++) begin
         apb(1'h0, `CBL_OFF_STAT, 32'h0000_0000);
         if (rd[0] === 1'h0)
            break;
      end
      if (k >= 300) begin
         num_errors++;
         summarize();
      end
   endtask
   task automatic code(input logic [7:0] e);
      apb(1'h0, `CBL_OFF_STAT, 32'h0000_0000);
      `CHK(rd[15:8], e)
   endtask
   // Runs the table of plain copies, then the awkward cases.
   initial begin
      rows[0] = '{32'h0000_0001, 32'h0000_0000, 1'h1, 1'h1, 7, 7'h7f, 7'h70, 16'h0000};
      rows[1] = '{32'h0000_0003, 32'h0000_0000, 1'h1, 1'h1, 4, 7'h0f, 7'h00, 16'h0000};
      rows[2] = '{32'h0000_001f, 32'h0000_0203, 1'h1, 1'h1, 8, 7'h7f, 7'h00, 16'h1800};
      rows[3] = '{32'h0000_001f, 32'h0000_0203, 1'h0, 1'h0, 5, 7'h1f, 7'h00, 16'h0000};
      rows[4] = '{32'h0000_001d, 32'h0000_0203, 1'h1, 1'h1, 8, 7'h7f, 7'h00, 16'h1800};
      clr();
      repeat (12) @(posedge clock_in);
      reset_n_in <= 1'h1;
      wait_idle();
      `CHK(n_req, 0)
      for (i = 0; i < 5; i++) begin
         cassette_comment_in <= rows[i].com;
         cassette_flash_in <= rows[i].fl;
         go(rows[i].ctrl, rows[i].blk);
         wait_idle();
         `CHK(n_req, rows[i].n)
         `CHK(ids, rows[i].ids)
         `CHK(ers, rows[i].ers)
         `CHK(fa, rows[i].fa)
         `CHK(rd[15:8], `CBL_ERR_NONE)
         $display("row %0d done", i);
      end
      `CHK(rd[7:0], 8'hee)
      apb(1'h0, `CBL_OFF_CTRL, 32'h0000_0000);
      `CHK(rd, 32'h0000_001c)
      apb(1'h0, `CBL_OFF_BLK, 32'h0000_0000);
      `CHK(rd, 32'h0000_0203)
      `CHK(irq_out, 1'h0)
      apb(1'h1, `CBL_OFF_IRQM, 32'h0000_0007);
      @(negedge clock_in);
      `CHK(irq_out, 1'h1)
      apb(1'h1, `CBL_OFF_IRQS, 32'h0000_0007);
      @(negedge clock_in);
      `CHK(irq_out, 1'h0)
      apb(1'h0, 8'h1c, 32'h0000_0000);
      `CHK({se, rd}, {1'h1, 32'h0000_0000})
      unconverted_in <= 1'h1;
      go(32'h0000_0001, 32'h0000_0000);
      code(`CBL_ERR_PROC);
      `CHK(n_req, 0)
      unconverted_in <= 1'h0;
      @(posedge clock_in);
      edit_request_in <= 1'h1;
      @(posedge clock_in);
      edit_request_in <= 1'h0;
      @(negedge clock_in);
      `CHK(edit_refused_out, 1'h1)
      code(`CBL_ERR_PROT);
      slow <= 1'h1;
      go(32'h0000_001d, 32'h0000_0203);
      apb(1'h1, `CBL_OFF_CTRL, 32'h0000_0001);
      code(`CBL_ERR_BUSY);
      wait_idle();
      `CHK(n_req, 8)
      slow <= 1'h0;
      $display("refusal tests done");
      func_switch_in <= 1'h0;
      go(32'h0000_0001, 32'h0000_0000);
      code(`CBL_ERR_NOSTORE);
      apb(1'h1, `CBL_OFF_TIME, 32'h0000_0000);
      apb(1'h1, `CBL_OFF_DATE, 32'h630c_1f06);
      apb(1'h1, `CBL_OFF_TIME, 32'h0017_3b3b);
      repeat (TICK + 5) @(posedge clock_in);
      apb(1'h0, `CBL_OFF_TIME, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
      apb(1'h0, `CBL_OFF_DATE, 32'h0000_0000);
      `CHK(rd, 32'h0001_0100)
      `CHK(n_req, 0)
      func_switch_in <= 1'h1;
      $display("clock test done");
      clr();
      @(posedge clock_in);
      run_mode_in <= 1'h1;
      wait_idle();
      `CHK(n_req, 8)
      `CHK({ids, rst_all}, {7'h7f, 1'h1})
      go(32'h0000_0003, 32'h0000_0000);
      code(`CBL_ERR_MODE);
      match <= 1'h1;
      run_mode_in <= 1'h0;
      apb(1'h1, `CBL_OFF_IRQS, 32'h0000_0007);
      clr();
      run_mode_in <= 1'h1;
      wait_idle();
      `CHK(n_req, 0)
      apb(1'h0, `CBL_OFF_IRQS, 32'h0000_0000);
      `CHK(rd[0], 1'h1)
      match <= 1'h0;
      $display("run entry tests done");
      cassette_present_in <= 1'h0;
      repeat (3) @(posedge clock_in);
      apb(1'h0, `CBL_OFF_IRQS, 32'h0000_0000);
      `CHK({rd[2], irq_out}, 2'h3)
      code(`CBL_ERR_IOCHK);
      cassette_present_in <= 1'h1;
      repeat (3) @(posedge clock_in);
      clr();
      reset_n_in <= 1'h0;
      repeat (2) @(posedge clock_in);
      reset_n_in <= 1'h1;
      wait_idle();
      `CHK({ids[3:0], rst_all}, {4'hf, 1'h1})
      $display("power-up test done");
      summarize();
   end
endmodule
`default_nettype wire
